// >>> logic/oag_pkg.sv
// Package: constants and carrier types for the operand address generator
`default_nettype none
package oag_pkg;
   // Address modes presented with each request
   typedef enum logic [2:0]
   {
      OAG_MODE_SHORT,
      OAG_MODE_SFR,
      OAG_MODE_INDIRECT,
      OAG_MODE_BASED,
      OAG_MODE_BASED_INDEXED,
      OAG_MODE_STACK
   } oag_mode_t;

   // Short direct window
   localparam logic [15:0] OAG_SHORT_LO = 16'hFE20;
   localparam logic [15:0] OAG_SHORT_HI = 16'hFF1F;
   localparam logic [7:0] OAG_SHORT_HIGH_BYTE = 8'hFE;
   localparam logic [7:0] OAG_SHORT_WRAP = 8'h20;
   localparam int OAG_SHORT_CARRY_BIT = 8;
   // Special function register window
   localparam logic [7:0] OAG_SFR_HIGH_BYTE = 8'hFF;
   localparam logic [7:0] OAG_SFR_HOLE_LO = 8'hD0;
   localparam logic [7:0] OAG_SFR_HOLE_HI = 8'hDF;
   // Internal high-speed RAM bounds (stack area), defaults of our own
   localparam logic [15:0] OAG_HSRAM_LO = 16'hFB00;
   localparam logic [15:0] OAG_HSRAM_HI = 16'hFEFF;
   // Reset value and bank count
   localparam logic [15:0] OAG_ADDR_RESET = 16'h0000;
   localparam int OAG_BANKS = 4;

   // One request from the decoder
   typedef struct packed
   {
      oag_mode_t mode;       // Address mode
      logic [7:0] imm;       // Instruction immediate byte
      logic pair_sel;        // 0 = pointer_pair_one, 1 = base_pair
      logic index_sel;       // 0 = lower index, 1 = upper index
      logic word;            // 16-bit operand
   } oag_req_t;

   // One answer on the internal address bus
   typedef struct packed
   {
      logic [15:0] addr;     // Effective address
      logic word;            // Byte pair access
      logic fault;           // Address refused by the mode
   } oag_resp_t;
endpackage
`default_nettype wire

// >>> logic/oag_bank_file.sv
// Banked register pair store: one set of pairs per bank, registered read
`timescale 1ns/1ns
`default_nettype none
module oag_bank_file
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic wr_en,                 // Write a bank's pairs
   input wire logic [1:0] wr_bank,         // Bank to write
   input wire logic [15:0] wr_pair_one,    // pointer_pair_one value
   input wire logic [15:0] wr_base,        // base_pair value
   input wire logic [15:0] wr_index,       // Upper and lower index bytes
   input wire logic [1:0] rd_bank,         // Bank to read
   output logic [15:0] rd_pair_one,
   output logic [15:0] rd_base,
   output logic [15:0] rd_index
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [47:0] mem_reg [oag_pkg::OAG_BANKS];

   // Bank writes; reset clears nothing, the core reloads the pairs
   always_ff @(posedge clk)
   begin
      if (ce && wr_en)
      begin
         mem_reg[wr_bank] <= {wr_pair_one, wr_base, wr_index};
      end
   end

   // Registered read of the chosen bank
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         {rd_pair_one, rd_base, rd_index} <= 48'h000000000000;
      end
      else if (ce)
      begin
         {rd_pair_one, rd_base, rd_index} <= mem_reg[rd_bank];
      end
   end
endmodule // oag_bank_file
`default_nettype wire

// >>> logic/oag_operand_address_generator.sv
// Operand effective-address generator for the 8-bit core
// How it works
// - Short direct reaches only FE20H..FF1FH.
// - Immediate 20H..FFH gives 0, else 1.
// - That bit is address bit 8; high FE.
// - Short direct word access needs even address.
// - SFR mode reaches FF00H..FFCFH, FFE0H..FFFFH only.
// - FF00H..FF1FH reachable by both modes.
// - SFR word access needs even address.
// - Indirect uses full selected pair as address.
// - Indirect pair comes from flag-selected bank.
// - Based adds zero-extended byte, carry dropped.
// - Base pair comes from flag-selected bank.
// - Based indexed adds zero-extended index register.
// - Stack mode uses stack pointer as address.
// - Stack confined to internal high-speed RAM.
`timescale 1ns/1ns
`default_nettype none
module oag_operand_address_generator
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,                       // Freezes all state when low
   input wire logic req_valid,                // Request strobe, one cycle
   input wire oag_pkg::oag_req_t req,         // Request fields
   input wire logic bank_select_low,          // Bank flag, low bit
   input wire logic bank_select_high,         // Bank flag, high bit
   input wire logic [15:0] stack_ptr,         // Stack pointer contents
   input wire logic bank_wr_en,               // Register bank update
   input wire logic [1:0] bank_wr_sel,
   input wire logic [15:0] bank_wr_pair_one,
   input wire logic [15:0] bank_wr_base,
   input wire logic [15:0] bank_wr_index,
   output logic resp_valid,                   // Answer strobe, one cycle
   output oag_pkg::oag_resp_t resp            // Answer fields
);
   // ----------------------------------------
   // Bank selection and pair store
   // ----------------------------------------
   // The two bank flags come from the core's own status logic on this clock,
   // so they are read without synchronisers. A flag change takes effect for
   // the request taken on the same edge, never for one already in flight.
   wire logic [1:0] bank_sel = {bank_select_high, bank_select_low}; // Chosen bank
   wire logic [15:0] pair_one_q;   // pointer_pair_one of chosen bank
   wire logic [15:0] base_q;       // base_pair of chosen bank
   wire logic [15:0] index_q;      // Upper and lower index bytes

   // Pairs read from the bank named by the flags
   oag_bank_file u_bank
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wr_en(bank_wr_en),
      .wr_bank(bank_wr_sel),
      .wr_pair_one(bank_wr_pair_one),
      .wr_base(bank_wr_base),
      .wr_index(bank_wr_index),
      .rd_bank(bank_sel),
      .rd_pair_one(pair_one_q),
      .rd_base(base_q),
      .rd_index(index_q)
   );

   // ----------------------------------------
   // Request stage
   // ----------------------------------------
   // The bank read is registered, so the request waits one cycle beside it.
   // Trade-off: one extra cycle of latency buys a short path from the bank
   // store into the adders, which sit between two register stages.
   logic stage_valid_reg;
   oag_pkg::oag_req_t stage_req_reg;
   logic [15:0] stage_sp_reg;

   // Capture request alongside the bank read
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stage_valid_reg <= 1'b0;
         stage_req_reg <= '0;
         stage_sp_reg <= oag_pkg::OAG_ADDR_RESET;
      end
      else if (ce)
      begin
         stage_valid_reg <= req_valid;
         stage_req_reg <= req;
         stage_sp_reg <= stack_ptr;
      end
   end

   // ----------------------------------------
   // Address forming
   // ----------------------------------------
   wire logic [7:0] imm = stage_req_reg.imm;
   // Low immediates wrap into FF00H..FF1FH via bit 8
   wire logic short_bit8 = (imm < oag_pkg::OAG_SHORT_WRAP);
   // High byte FE with bit 8 injected; window FE20H..FF1FH only
   wire logic [15:0] short_addr =
      {oag_pkg::OAG_SHORT_HIGH_BYTE[7:1], short_bit8, imm};
   // SFR address: high byte all ones
   wire logic [15:0] sfr_addr = {oag_pkg::OAG_SFR_HIGH_BYTE, imm};
   // FFD0H..FFDFH lies outside the SFR mode
   wire logic sfr_hole = (imm >= oag_pkg::OAG_SFR_HOLE_LO) &&
      (imm <= oag_pkg::OAG_SFR_HOLE_HI);
   // Full pair as pointer
   wire logic [15:0] ind_addr = stage_req_reg.pair_sel ? base_q : pair_one_q;
   // Zero-extended offset, 16-bit sum drops the carry
   wire logic [15:0] based_addr = 16'(base_q + {8'h00, imm});
   // Zero-extended index register, carry dropped
   wire logic [7:0] index_byte = stage_req_reg.index_sel ? index_q[15:8] : index_q[7:0];
   wire logic [15:0] bidx_addr = 16'(base_q + {8'h00, index_byte});
   // Stack pointer straight through
   wire logic [15:0] stack_addr = stage_sp_reg;
   // Stack outside high-speed RAM is refused
   wire logic stack_out = (stack_addr < oag_pkg::OAG_HSRAM_LO) ||
      (stack_addr > oag_pkg::OAG_HSRAM_HI);
   // Odd immediate for word access is refused in short direct and SFR modes
   wire logic odd_word = stage_req_reg.word && imm[0];

   // Mode selection; a faulted request still carries its computed address,
   // so the consumer must look at the fault bit before using it
   logic [15:0] addr_sel;
   logic fault_sel;
   always_comb
   begin
      addr_sel = oag_pkg::OAG_ADDR_RESET;
      fault_sel = 1'b0;
      case (stage_req_reg.mode)
         oag_pkg::OAG_MODE_SHORT:
         begin
            addr_sel = short_addr;
            fault_sel = odd_word;
         end
         oag_pkg::OAG_MODE_SFR:
         begin
            addr_sel = sfr_addr;
            fault_sel = odd_word || sfr_hole;
         end
         oag_pkg::OAG_MODE_INDIRECT:
         begin
            addr_sel = ind_addr;
         end
         oag_pkg::OAG_MODE_BASED:
         begin
            addr_sel = based_addr;
         end
         oag_pkg::OAG_MODE_BASED_INDEXED:
         begin
            addr_sel = bidx_addr;
         end
         oag_pkg::OAG_MODE_STACK:
         begin
            addr_sel = stack_addr;
            fault_sel = stack_out;
         end
         default:
         begin
            // Unknown mode: refuse it
            fault_sel = 1'b1;
         end
      endcase
   end

   // ----------------------------------------
   // Answer register
   // ----------------------------------------
   // Outputs come straight from flip-flops. The answer fields hold between
   // strobes so a slow consumer may read them late; only the strobe pulses.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         resp_valid <= 1'b0;
         resp <= '0;
      end
      else if (ce)
      begin
         resp_valid <= stage_valid_reg;
         if (stage_valid_reg)
         begin
            resp.addr <= addr_sel;
            resp.word <= stage_req_reg.word;
            resp.fault <= fault_sel;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_short_window: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_SHORT) |=>
      (resp.addr >= 16'hFE20 && resp.addr <= 16'hFF1F))
      else $error("short direct address outside window");
   chk_short_bit8: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_SHORT) |=>
      (resp.addr[8] == ($past(imm) < 8'h20)))
      else $error("short direct bit 8 wrong");
   chk_short_high: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_SHORT) |=>
      (resp.addr[15:9] == 7'h7F && resp.addr[7:0] == $past(imm)))
      else $error("short direct upper bits wrong");
   chk_word_even: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.word && imm[0] &&
      (stage_req_reg.mode == oag_pkg::OAG_MODE_SHORT ||
      stage_req_reg.mode == oag_pkg::OAG_MODE_SFR)) |=> resp.fault)
      else $error("odd word address not refused");
   chk_sfr_hole: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_SFR &&
      imm[7:4] == 4'hD) |=> resp.fault)
      else $error("sfr hole not refused");
   chk_sfr_addr: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_SFR) |=>
      (resp.addr == {8'hFF, $past(imm)}))
      else $error("sfr address wrong");
   chk_based_sum: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_BASED) |=>
      (resp.addr == 16'($past(base_q) + {8'h00, $past(imm)})))
      else $error("based address wrong");
   chk_stack_ram: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_STACK) |=>
      (resp.addr == $past(stage_sp_reg) && resp.fault == $past(stack_out)))
      else $error("stack address or confinement wrong");
   chk_resp_latency: assert property (@(posedge clk) disable iff (rst)
      (ce && req_valid) ##1 ce |=> resp_valid)
      else $error("answer not two cycles after request");

   // ----------------------------------------
   // Checks on shared windows and pointers
   // ----------------------------------------
   // Low SFR immediates land in the range short direct also reaches
   chk_sfr_low_shared: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_SFR &&
      imm < 8'h20) |=> (resp.addr >= 16'hFF00 && resp.addr <= 16'hFF1F))
      else $error("sfr low range not shared");
   // Low short direct immediates reach the same registers
   chk_short_low_shared: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_SHORT &&
      imm < 8'h20) |=> (resp.addr >= 16'hFF00 && resp.addr <= 16'hFF1F))
      else $error("short low range not shared");
   // Indirect answer is the chosen pair, untouched
   chk_indirect_addr: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_INDIRECT) |=>
      (resp.addr == ($past(stage_req_reg.pair_sel) ? $past(base_q) : $past(pair_one_q))))
      else $error("indirect address wrong");
   // Indirect may reach every location, so it is never refused
   chk_indirect_clean: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_INDIRECT) |=>
      !resp.fault)
      else $error("indirect address refused");
   // Based forms reach every location as well
   chk_based_clean: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && (stage_req_reg.mode == oag_pkg::OAG_MODE_BASED ||
      stage_req_reg.mode == oag_pkg::OAG_MODE_BASED_INDEXED)) |=> !resp.fault)
      else $error("based address refused");
   // Based indexed sum with the chosen index byte, carry dropped
   chk_bidx_sum: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg &&
      stage_req_reg.mode == oag_pkg::OAG_MODE_BASED_INDEXED) |=>
      (resp.addr == 16'($past(base_q) + {8'h00, ($past(stage_req_reg.index_sel) ?
      $past(index_q[15:8]) : $past(index_q[7:0]))})))
      else $error("based indexed address wrong");

   // ----------------------------------------
   // Checks on refusals and hold
   // ----------------------------------------
   // Even SFR word outside the hole is accepted
   chk_sfr_word_ok: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_SFR &&
      stage_req_reg.word && !imm[0] && imm[7:4] != 4'hD) |=> !resp.fault)
      else $error("even sfr word refused");
   // Even short direct word is accepted
   chk_short_word_ok: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_SHORT &&
      !imm[0]) |=> !resp.fault)
      else $error("even short word refused");
   // Stack inside high-speed RAM is accepted
   chk_stack_in_ram: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode == oag_pkg::OAG_MODE_STACK &&
      stage_sp_reg >= 16'hFB00 && stage_sp_reg <= 16'hFEFF) |=> !resp.fault)
      else $error("stack inside ram refused");
   // Word flag travels with the answer
   chk_resp_word: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg) |=> (resp.word == $past(stage_req_reg.word)))
      else $error("word flag lost");
   // No strobe without a staged request
   chk_idle_quiet: assert property (@(posedge clk) disable iff (rst)
      (ce && !stage_valid_reg) |=> !resp_valid)
      else $error("answer strobe without request");
   // Clock enable low freezes the answer
   chk_frozen_hold: assert property (@(posedge clk) disable iff (rst)
      !ce |=> ($stable(resp) && $stable(resp_valid)))
      else $error("answer moved while frozen");
   // Codes above the last mode are refused
   chk_unknown_mode: assert property (@(posedge clk) disable iff (rst)
      (ce && stage_valid_reg && stage_req_reg.mode > oag_pkg::OAG_MODE_STACK) |=>
      resp.fault)
      else $error("unknown mode not refused");
endmodule // oag_operand_address_generator
`default_nettype wire

// >>> verification/oag_mem_bus_model.sv
// Far-side model: memory and register bus that consumes address answers
`timescale 1ns/1ns
`default_nettype none
module oag_mem_bus_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic resp_valid,
   input wire oag_pkg::oag_resp_t resp,
   output logic [15:0] access_count
);
   // -----------------------------------------------------------------
   // Access counter
   // -----------------------------------------------------------------
   // A refused address must never reach memory, so only clean ones count
   always_ff @(posedge clk)
   begin
      if (rst)
         access_count <= 16'h0000;
      else if (resp_valid && !resp.fault)
         access_count <= access_count + 16'h0001;
   end
endmodule // oag_mem_bus_model
`default_nettype wire

// >>> verification/oag_operand_address_generator_test.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ns
`default_nettype none
module oag_operand_address_generator_test;
   // -----------------------------------------------------------------
   // Stimulus and observed signals
   // -----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic req_valid = 1'b0;
   oag_pkg::oag_req_t req = '0;
   logic bs_low = 1'b0;
   logic bs_high = 1'b0;
   logic [15:0] sp = 16'hFB00;
   logic wr_en = 1'b0;
   logic [1:0] wr_sel = 2'h0;
   logic [15:0] wr_one = 16'h0000;
   logic [15:0] wr_base = 16'h0000;
   logic [15:0] wr_index = 16'h0000;
   logic resp_valid;
   oag_pkg::oag_resp_t resp;
   logic [15:0] access_count;
   int err_total = 0;
   int samples_checked = 0;
   int clean_exp = 0; // Answers without fault that the bus should see
   always #10 clk = ~clk; // 50 MHz
   oag_operand_address_generator uut
   (
      .clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
      .bank_select_low(bs_low), .bank_select_high(bs_high), .stack_ptr(sp),
      .bank_wr_en(wr_en), .bank_wr_sel(wr_sel), .bank_wr_pair_one(wr_one),
      .bank_wr_base(wr_base), .bank_wr_index(wr_index),
      .resp_valid(resp_valid), .resp(resp)
   );
   oag_mem_bus_model bus
   (
      .clk(clk), .rst(rst), .resp_valid(resp_valid), .resp(resp),
      .access_count(access_count)
   );
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic results();
      $display("Checks made %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One strobed request, then wait a bounded time for the answer
   task automatic issue(input oag_pkg::oag_mode_t m, input logic [7:0] imm,
                        input logic ps, input logic is, input logic w,
                        input logic [15:0] ea, input logic ef);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{mode: m, imm: imm, pair_sel: ps, index_sel: is, word: w};
      @(posedge clk);
      req_valid <= 1'b0;
      for (n = 0; n < 6 && resp_valid !== 1'b1; n++)
      begin
         @(posedge clk);
         #1;
      end
      samples_checked++;
      if (n == 6)
      begin
         err_total++;
         $display("ERROR %0t no answer", $time);
         results();
      end
      if (resp.addr !== ea || resp.fault !== ef || resp.word !== w)
      begin
         err_total++;
         $display("ERROR %0t addr %h fault %b, want %h %b", $time, resp.addr,
                  resp.fault, ea, ef);
      end
      if (ef == 1'b0)
         clean_exp++;
   endtask
   // Load one bank's pairs
   task automatic load_bank(input logic [1:0] b, input logic [15:0] one,
                            input logic [15:0] base, input logic [15:0] idx);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_sel <= b;
      wr_one <= one;
      wr_base <= base;
      wr_index <= idx;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   // Window edges and the wrap of bit 8, odd word refused
   task automatic test_short();
      issue(oag_pkg::OAG_MODE_SHORT, 8'h20, 0, 0, 0, 16'hFE20, 0);
      issue(oag_pkg::OAG_MODE_SHORT, 8'hFF, 0, 0, 0, 16'hFEFF, 0);
      issue(oag_pkg::OAG_MODE_SHORT, 8'h00, 0, 0, 0, 16'hFF00, 0);
      issue(oag_pkg::OAG_MODE_SHORT, 8'h1F, 0, 0, 0, 16'hFF1F, 0);
      issue(oag_pkg::OAG_MODE_SHORT, 8'h30, 0, 0, 1, 16'hFE30, 0);
      issue(oag_pkg::OAG_MODE_SHORT, 8'h31, 0, 0, 1, 16'hFE31, 1);
      issue(oag_pkg::oag_mode_t'(3'h6), 8'h20, 0, 0, 0, 16'h0000, 1);
      $display("test_short done");
   endtask
   // Both edges of the hole and odd word refused
   task automatic test_sfr();
      issue(oag_pkg::OAG_MODE_SFR, 8'h00, 0, 0, 0, 16'hFF00, 0);
      issue(oag_pkg::OAG_MODE_SFR, 8'hCF, 0, 0, 0, 16'hFFCF, 0);
      issue(oag_pkg::OAG_MODE_SFR, 8'hD0, 0, 0, 0, 16'hFFD0, 1);
      issue(oag_pkg::OAG_MODE_SFR, 8'hDF, 0, 0, 0, 16'hFFDF, 1);
      issue(oag_pkg::OAG_MODE_SFR, 8'hE0, 0, 0, 1, 16'hFFE0, 0);
      issue(oag_pkg::OAG_MODE_SFR, 8'hFF, 0, 0, 1, 16'hFFFF, 1);
      $display("test_sfr done");
   endtask
   // Two banks loaded; the flags choose which one answers
   task automatic test_banks();
      load_bank(2'h1, 16'h1234, 16'hFFF0, 16'h80F0);
      load_bank(2'h2, 16'h0102, 16'h8000, 16'h0000);
      bs_low <= 1'b1;
      issue(oag_pkg::OAG_MODE_INDIRECT, 8'h00, 0, 0, 0, 16'h1234, 0);
      issue(oag_pkg::OAG_MODE_INDIRECT, 8'h00, 1, 0, 0, 16'hFFF0, 0);
      issue(oag_pkg::OAG_MODE_BASED, 8'h20, 0, 0, 0, 16'h0010, 0);
      issue(oag_pkg::OAG_MODE_BASED_INDEXED, 8'h00, 0, 1, 0, 16'h0070, 0);
      issue(oag_pkg::OAG_MODE_BASED_INDEXED, 8'h00, 0, 0, 0, 16'h00E0, 0);
      bs_low <= 1'b0;
      bs_high <= 1'b1;
      issue(oag_pkg::OAG_MODE_INDIRECT, 8'h00, 0, 0, 0, 16'h0102, 0);
      issue(oag_pkg::OAG_MODE_BASED, 8'hFF, 0, 0, 0, 16'h80FF, 0);
      $display("test_banks done");
   endtask
   // Stack pointer passed through; outside high-speed RAM refused
   task automatic test_stack();
      sp <= 16'hFB00;
      issue(oag_pkg::OAG_MODE_STACK, 8'h00, 0, 0, 0, 16'hFB00, 0);
      sp <= 16'hFEFF;
      issue(oag_pkg::OAG_MODE_STACK, 8'h00, 0, 0, 0, 16'hFEFF, 0);
      sp <= 16'hFF00;
      issue(oag_pkg::OAG_MODE_STACK, 8'h00, 0, 0, 0, 16'hFF00, 1);
      sp <= 16'hFAFF;
      issue(oag_pkg::OAG_MODE_STACK, 8'h00, 0, 0, 0, 16'hFAFF, 1);
      $display("test_stack done");
   endtask
   // Clock enable low holds a staged answer back; a mid-run reset clears it
   task automatic test_freeze_reset();
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{mode: oag_pkg::OAG_MODE_SHORT, imm: 8'h40, pair_sel: 0, index_sel: 0, word: 0};
      @(posedge clk);
      req_valid <= 1'b0;
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      samples_checked++;
      if (resp_valid !== 1'b0 || resp.addr !== 16'h0000)
      begin
         err_total++;
         $display("ERROR %0t answer moved while frozen", $time);
      end
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      #1;
      samples_checked++;
      if (resp_valid !== 1'b1 || resp.addr !== 16'hFE40 || resp.fault !== 1'b0)
      begin
         err_total++;
         $display("ERROR %0t frozen answer lost, addr %h", $time, resp.addr);
      end
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      clean_exp = 0;
      samples_checked++;
      if (resp_valid !== 1'b0 || resp !== '0 || access_count !== 16'h0000)
      begin
         err_total++;
         $display("ERROR %0t reset did not clear the answer", $time);
      end
      $display("test_freeze_reset done");
   endtask
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      test_freeze_reset();
      test_short();
      test_sfr();
      test_banks();
      test_stack();
      repeat (2) @(posedge clk);
      samples_checked++;
      if (access_count !== 16'(clean_exp))
      begin
         err_total++;
         $display("ERROR %0t bus saw %0d accesses", $time, access_count);
      end
      results();
   end
endmodule // oag_operand_address_generator_test
`default_nettype wire
